/* core/dfs_drive_aux.sv */
// direction lock, carrier select, s-curve ramp, jump bands and manual voltage reduction
module dfs_drive_aux
  import dfs_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic run_fwd_in,
  input wire logic run_rev_in,
  input wire logic [1:0] dir_lock_in,
  input wire dfs_ctrl_mode_t ctrl_mode_in,
  input wire logic high_freq_mode_in,
  input wire logic [4:0] carrier_set_in,
  input wire logic [4:0] var_carr_max_in,
  input wire logic soft_pwm_en_in,
  input wire logic auto_lower_en_in,
  input wire logic overheat_in,
  input wire logic [16:0] freq_ref_in,
  input wire logic [16:0] freq_max_in,
  input wire logic [15:0] acc_time_in,
  input wire logic [15:0] dec_time_in,
  input wire logic [3:0][7:0] s_time_in,
  input wire logic [2:0][13:0] jump_freq_in,
  input wire logic [7:0] jump_width_in,
  input wire logic [3:0] ai2_func_in,
  input wire logic [13:0] ai2_value_in,
  input wire logic [NUM_DI-1:0] di_level_in,
  input wire logic [NUM_DI-1:0][5:0] digital_input_function_select_in,
  input wire logic [6:0] mes_gain_in,
  input wire logic [16:0] mes_freq_in,
  input wire logic speed_ok_in,
  input wire logic [15:0] volt_recov_time_in,
  output logic [4:0] carrier_khz_out,
  output logic [16:0] freq_out,
  output logic dir_rev_out,
  output logic running_out,
  output logic [6:0] volt_pct_out,
  output logic manual_voltage_reduction_out
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  localparam int NSYNC = NUM_DI + 3;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  logic [NSYNC-1:0] s3_q;
  logic [NSYNC-1:0] pin_q;

  assign pin_raw = {di_level_in, overheat_in, run_rev_in, run_fwd_in};

  // three stages, a change counts once stages two and three agree
  for (genvar b = 0; b < NSYNC; b++) begin : g_sync
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
        s1_q[b] <= 1'b0;
        s2_q[b] <= 1'b0;
        s3_q[b] <= 1'b0;
        pin_q[b] <= 1'b0;
      end else begin
        s1_q[b] <= pin_raw[b];
        s2_q[b] <= s1_q[b];
        s3_q[b] <= s2_q[b];
        if (s2_q[b] == s3_q[b]) begin
          pin_q[b] <= s3_q[b];
        end
      end
    end
  end

  // ****************************************
  // tick divider
  // ****************************************
  logic [31:0] tick_cnt_q;
  logic tick;

  assign tick = (tick_cnt_q == 32'(TICK_CYCLES_P - 1));

  // one-cycle enable every 10 ms
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
    end
  end

  // ****************************************
  // direction lock
  // ****************************************
  logic fwd_ok;
  logic rev_ok;
  logic want_run;
  logic dir_rev_q;
  logic running_q;
  logic [16:0] freq_q;

  assign fwd_ok = pin_q[0] && (dir_lock_in != LOCK_REV);
  assign rev_ok = pin_q[1] && (dir_lock_in != LOCK_FWD);
  assign want_run = fwd_ok ^ rev_ok;

  // direction flips only once the output has ramped to zero
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dir_rev_q <= 1'b0;
      running_q <= 1'b0;
    end else begin
      if (want_run && freq_q == 17'h0_0000) begin
        dir_rev_q <= rev_ok;
      end
      running_q <= want_run || (freq_q != 17'h0_0000);
    end
  end

  // ****************************************
  // jump bands
  // ****************************************
  dfs_jump_if jmp ();
  logic [13:0] jump_lim;
  logic [3:0][13:0] jpt;
  logic [16:0] ref_lim;

  assign jump_lim = high_freq_mode_in ? JUMP_MAX_HF : JUMP_MAX_STD;
  assign jpt[3] = (ai2_func_in == AI2_FUNC_JUMP) ? ai2_value_in : 14'h0000;
  assign ref_lim = (freq_ref_in > freq_max_in) ? freq_max_in : freq_ref_in;

  for (genvar j = 0; j < 3; j++) begin : g_jpt
    assign jpt[j] = jump_freq_in[j];
  end

  for (genvar j = 0; j < NUM_JUMP; j++) begin : g_pt
    assign jmp.point[j] = 17'((jpt[j] > jump_lim ? jump_lim : jpt[j]) * JUMP_SCALE);
  end

  assign jmp.width = 17'(jump_width_in * JUMP_SCALE);
  // lock is applied before exclusion; a locked command gives zero target
  assign jmp.ref_freq = (want_run && rev_ok == dir_rev_q) ? ref_lim : 17'h0_0000;

  dfs_jump_band u_band (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .jmp(jmp)
  );

  // ****************************************
  // s-curve ramp
  // ****************************************
  logic [3:0][7:0] s_t;
  logic accel;
  logic [16:0] total;
  logic [7:0] s_end;
  logic [16:0] rem;
  logic end_zone;
  dfs_ramp_ph_t ph_q;
  logic up_q;
  logic [7:0] ph_cnt_q;
  logic [31:0] acc_q;
  logic [16:0] tgt;

  for (genvar s = 0; s < 4; s++) begin : g_st
    assign s_t[s] = (s_time_in[s] > S_TIME_MAX) ? S_TIME_MAX : s_time_in[s];
  end

  assign tgt = jmp.excluded;
  assign accel = (tgt > freq_q);
  assign total = accel ? 17'(acc_time_in) + ((17'(s_t[0]) + 17'(s_t[1])) >> 1)
                       : 17'(dec_time_in) + ((17'(s_t[2]) + 17'(s_t[3])) >> 1);
  assign s_end = accel ? s_t[1] : s_t[3];
  assign rem = accel ? tgt - freq_q : freq_q - tgt;
  // remaining distance fits in a half-rate end segment
  assign end_zone = (40'(rem) * 40'(total) * 40'h00_0000_0002) <= (40'(freq_max_in) * 40'(s_end));

  // phase sequencing of start, linear and end segments
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ph_q <= PH_HOLD;
      up_q <= 1'b0;
      ph_cnt_q <= 8'h00;
    end else begin
      case (ph_q)
        PH_HOLD: begin
          if (freq_q != tgt) begin
            ph_q <= PH_START;
            up_q <= accel;
            ph_cnt_q <= 8'h00;
          end
        end
        PH_START: begin
          if (tick) begin
            ph_cnt_q <= ph_cnt_q + 8'h01;
          end
          if (ph_cnt_q >= (up_q ? s_t[0] : s_t[2])) begin
            ph_q <= PH_LINEAR;
          end
        end
        PH_LINEAR: begin
          if (end_zone) begin
            ph_q <= PH_END;
          end
        end
        default: begin
        end
      endcase
      if (ph_q != PH_HOLD && freq_q == tgt) begin
        ph_q <= PH_HOLD;
      end else if (ph_q != PH_HOLD && accel != up_q) begin
        ph_q <= PH_START;
        up_q <= accel;
        ph_cnt_q <= 8'h00;
      end
    end
  end

  // rate accumulator steps the output one unit at a time through any band; with zero total time the output takes the target at once
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      acc_q <= 32'h0000_0000;
      freq_q <= 17'h0_0000;
    end else if (ph_q == PH_HOLD) begin
      acc_q <= 32'h0000_0000;
    end else if (total == 17'h0_0000) begin
      freq_q <= tgt;
    end else if (tick) begin
      acc_q <= acc_q + ((ph_q == PH_LINEAR) ? 32'(freq_max_in) : 32'(freq_max_in >> 1));
    end else if (acc_q >= 32'(total) && freq_q != tgt) begin
      acc_q <= acc_q - 32'(total);
      freq_q <= accel ? freq_q + 17'h0_0001 : freq_q - 17'h0_0001;
    end
  end

  // ****************************************
  // carrier selection
  // ****************************************
  logic vector_mode;
  logic [4:0] cfg;
  logic [4:0] cfg_q;
  logic [4:0] lower_q;
  logic [7:0] therm_cnt_q;
  logic [4:0] carr_q;

  assign vector_mode = (ctrl_mode_in == MODE_SENSORLESS_VECTOR) || (ctrl_mode_in == MODE_ENCODER_VECTOR);

  // configured carrier from the setting
  always_comb begin
    cfg = cfg_q;
    if (carrier_set_in >= CARR_MIN && carrier_set_in <= CARR_MAX) begin
      cfg = carrier_set_in;
    end else if (carrier_set_in == CARR_VAR) begin
      cfg = (var_carr_max_in < CARR_MIN) ? CARR_MIN : var_carr_max_in;
      if (cfg > CARR_MAX) begin
        cfg = CARR_MAX;
      end
    end
    if (vector_mode && cfg < CARR_VEC_MIN) begin
      cfg = CARR_VEC_MIN;
    end
    if (soft_pwm_en_in && cfg > CARR_SOFT_MAX) begin
      cfg = CARR_SOFT_MAX;
    end
  end

  // thermal lowering steps down once a second, clears when cool
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cfg_q <= CARR_MIN;
      lower_q <= 5'h00;
      therm_cnt_q <= 8'h00;
      carr_q <= CARR_MIN;
    end else begin
      cfg_q <= cfg;
      if (!auto_lower_en_in || !pin_q[2]) begin
        lower_q <= 5'h00;
        therm_cnt_q <= 8'h00;
      end else if (tick) begin
        therm_cnt_q <= (therm_cnt_q == 8'(THERM_STEP_TICKS - 1)) ? 8'h00 : therm_cnt_q + 8'h01;
        if (therm_cnt_q == 8'(THERM_STEP_TICKS - 1) && lower_q + CARR_MIN < cfg) begin
          lower_q <= lower_q + 5'h01;
        end
      end
      carr_q <= (lower_q >= cfg - CARR_MIN) ? CARR_MIN : cfg - lower_q;
    end
  end

  // ****************************************
  // manual voltage reduction
  // ****************************************
  logic [NUM_DI-1:0] mes_hit;
  logic mes_act;
  logic mes_q;
  logic [6:0] pct_tgt;
  logic [6:0] pct_q;
  logic [23:0] vacc_q;

  for (genvar d = 0; d < NUM_DI; d++) begin : g_mes
    assign mes_hit[d] = pin_q[3+d] && (digital_input_function_select_in[d] == DI_FUNC_MES);
  end

  assign mes_act = (|mes_hit) && (freq_ref_in > (mes_freq_in > MES_FREQ_MAX ? MES_FREQ_MAX : mes_freq_in))
                   && speed_ok_in;
  assign pct_tgt = mes_act ? ((mes_gain_in > PCT_FULL) ? PCT_FULL : mes_gain_in) : PCT_FULL;

  // full swing takes the recovery time, smaller changes proportionally less
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mes_q <= 1'b0;
      pct_q <= PCT_FULL;
      vacc_q <= 24'h00_0000;
    end else begin
      mes_q <= mes_act;
      if (pct_q == pct_tgt) begin
        vacc_q <= 24'h00_0000;
      end else if (volt_recov_time_in == 16'h0000) begin
        pct_q <= pct_tgt;
      end else if (tick) begin
        vacc_q <= vacc_q + 24'(PCT_FULL);
      end else if (vacc_q >= 24'(volt_recov_time_in)) begin
        vacc_q <= vacc_q - 24'(volt_recov_time_in);
        pct_q <= (pct_q > pct_tgt) ? pct_q - 7'h01 : pct_q + 7'h01;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign carrier_khz_out = carr_q;
  assign freq_out = freq_q;
  assign dir_rev_out = dir_rev_q;
  assign running_out = running_q;
  assign volt_pct_out = pct_q;
  assign manual_voltage_reduction_out = mes_q;
endmodule : dfs_drive_aux

/* core/dfs_pkg.sv */
// constants and types for the drive frequency shaping and carrier block
package dfs_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_MS = 10; // ramp and timer base, 0.01 s
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int THERM_STEP_TICKS = 100; // carrier lowering step every 1 s
  // ****************************************
  // widths and scaling
  // ****************************************
  localparam int FREQ_W = 17; // frequencies in 0.01 Hz
  localparam int NUM_JUMP = 4;
  localparam int NUM_DI = 8;
  localparam logic [4:0] JUMP_SCALE = 5'h0a; // 0.1 Hz to 0.01 Hz
  // ****************************************
  // settings
  // ****************************************
  localparam logic [1:0] LOCK_FWD = 2'h1;
  localparam logic [1:0] LOCK_REV = 2'h2;
  localparam logic [4:0] CARR_VAR = 5'h00;
  localparam logic [4:0] CARR_MIN = 5'h02;
  localparam logic [4:0] CARR_MAX = 5'h10;
  localparam logic [4:0] CARR_VEC_MIN = 5'h04;
  localparam logic [4:0] CARR_SOFT_MAX = 5'h08;
  localparam logic [7:0] S_TIME_MAX = 8'hfa; // 2.50 s
  localparam logic [13:0] JUMP_MAX_STD = 14'h0fa0; // 400.0 Hz
  localparam logic [13:0] JUMP_MAX_HF = 14'h2ee0; // 1200.0 Hz
  localparam logic [7:0] JUMP_WIDTH_MAX = 8'hff; // 25.5 Hz
  localparam logic [16:0] MES_FREQ_MAX = 17'h0_9c40; // 400.00 Hz
  localparam logic [5:0] DI_FUNC_MES = 6'h14;
  localparam logic [3:0] AI2_FUNC_JUMP = 4'h9;
  localparam logic [6:0] PCT_FULL = 7'h64;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    MODE_VF, MODE_VF_ENCODER, MODE_SENSORLESS_VECTOR, MODE_ENCODER_VECTOR
  } dfs_ctrl_mode_t;
  typedef enum logic [1:0] {PH_HOLD, PH_START, PH_LINEAR, PH_END} dfs_ramp_ph_t;
endpackage : dfs_pkg

/* core/dfs_jump_if.sv */
// jump band request and result between ramp path and band filter
interface dfs_jump_if;
  logic [16:0] ref_freq;
  logic [3:0][16:0] point;
  logic [16:0] width;
  logic [16:0] excluded;
  modport main (output ref_freq, output point, output width, input excluded);
  modport band (input ref_freq, input point, input width, output excluded);
endinterface : dfs_jump_if

/* core/dfs_jump_band.sv */
// jump band exclusion filter for the frequency target
module dfs_jump_band
  import dfs_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  dfs_jump_if.band jmp
);
  // ****************************************
  // band edges
  // ****************************************
  logic [16:0] lo [NUM_JUMP];
  logic [16:0] hi [NUM_JUMP];
  logic [NUM_JUMP-1:0] en;
  logic [16:0] f;

  // edges per jump point, zero point disables its band
  for (genvar j = 0; j < NUM_JUMP; j++) begin : g_band
    assign lo[j] = (jmp.point[j] > jmp.width) ? jmp.point[j] - jmp.width : 17'h0_0000;
    assign hi[j] = jmp.point[j] + jmp.width;
    assign en[j] = (jmp.point[j] != 17'h0_0000);
  end

  // ****************************************
  // exclusion
  // ****************************************
  // repeated passes push the target below chained bands
  always_comb begin
    f = jmp.ref_freq;
    for (int p = 0; p < NUM_JUMP; p++) begin
      for (int k = 0; k < NUM_JUMP; k++) begin
        if (en[k] && f > lo[k] && f < hi[k]) begin
          f = lo[k];
        end
      end
    end
  end

  // registered result
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      jmp.excluded <= 17'h0_0000;
    end else begin
      jmp.excluded <= f;
    end
  end
endmodule : dfs_jump_band

/* bench/dfs_drive_aux_properties.sv */
// concurrent checks on the ports of the drive auxiliary block
module dfs_drive_aux_properties
  import dfs_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic [1:0] dir_lock_in,
  input wire dfs_ctrl_mode_t ctrl_mode_in,
  input wire logic [4:0] carrier_set_in,
  input wire logic soft_pwm_en_in,
  input wire logic auto_lower_en_in,
  input wire logic [15:0] acc_time_in,
  input wire logic [15:0] dec_time_in,
  input wire logic [NUM_DI-1:0][5:0] digital_input_function_select_in,
  input wire logic [6:0] mes_gain_in,
  input wire logic speed_ok_in,
  input wire logic [15:0] volt_recov_time_in,
  input wire logic [4:0] carrier_khz_out,
  input wire logic [16:0] freq_out,
  input wire logic dir_rev_out,
  input wire logic [6:0] volt_pct_out,
  input wire logic manual_voltage_reduction_out
);
  logic mes_func_any;
  // any digital input assigned the voltage reduction function
  always_comb begin
    mes_func_any = 1'b0;
    for (int i = 0; i < NUM_DI; i++) begin
      if (digital_input_function_select_in[i] == DI_FUNC_MES) begin
        mes_func_any = 1'b1;
      end
    end
  end
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);
  // ****************************************
  // sequences
  // ****************************************
  sequence fixed_set;
    (carrier_set_in >= CARR_MIN && carrier_set_in <= CARR_MAX && $stable(carrier_set_in) && !soft_pwm_en_in
     && !auto_lower_en_in && (ctrl_mode_in == MODE_VF || ctrl_mode_in == MODE_VF_ENCODER))[*3];
  endsequence
  sequence vector_set;
    ((ctrl_mode_in == MODE_SENSORLESS_VECTOR || ctrl_mode_in == MODE_ENCODER_VECTOR) && !auto_lower_en_in
     && carrier_set_in >= CARR_MIN && carrier_set_in <= CARR_MAX)[*3];
  endsequence
  sequence ramp_timed;
    (acc_time_in != 16'h0000 && dec_time_in != 16'h0000)[*2];
  endsequence
  sequence fwd_only;
    (dir_lock_in == LOCK_FWD)[*6];
  endsequence
  // ****************************************
  // assertions
  // ****************************************
  a_fixed_carrier_val: assert property (fixed_set |-> carrier_khz_out == carrier_set_in)
    else $error("fixed carrier differs from its setting");
  a_vector_carrier_floor: assert property (vector_set |-> carrier_khz_out >= CARR_VEC_MIN)
    else $error("vector mode carrier below floor");
  a_soft_carrier_cap: assert property (soft_pwm_en_in [*3] |-> carrier_khz_out <= CARR_SOFT_MAX)
    else $error("randomised carrier above cap");
  a_carrier_in_range: assert property (carrier_khz_out >= CARR_MIN && carrier_khz_out <= CARR_MAX)
    else $error("carrier outside legal range");
  a_ramp_no_step: assert property (ramp_timed |=> (freq_out <= $past(freq_out) + 17'h0_0001)
    && ($past(freq_out) <= freq_out + 17'h0_0001))
    else $error("output frequency stepped during ramp");
  a_lock_no_reverse: assert property (fwd_only |-> !$rose(dir_rev_out))
    else $error("reverse taken while forward locked");
  a_reduce_needs_func: assert property ((!mes_func_any)[*5] |-> !manual_voltage_reduction_out)
    else $error("voltage reduction without assigned input");
  a_reduce_speed_gate: assert property ((!speed_ok_in)[*2] |-> !manual_voltage_reduction_out)
    else $error("voltage reduction with speed out of range");
  a_reduce_gain_level: assert property ((manual_voltage_reduction_out && volt_recov_time_in == 16'h0000
    && mes_gain_in <= PCT_FULL && $stable(mes_gain_in))[*3] |-> volt_pct_out == mes_gain_in)
    else $error("reduced voltage differs from gain");
endmodule : dfs_drive_aux_properties

bind dfs_drive_aux dfs_drive_aux_properties u_dfs_drive_aux_properties (.clk_sys_in, .resetn_in, .dir_lock_in,
  .ctrl_mode_in, .carrier_set_in, .soft_pwm_en_in, .auto_lower_en_in, .acc_time_in, .dec_time_in,
  .digital_input_function_select_in, .mes_gain_in, .speed_ok_in, .volt_recov_time_in, .carrier_khz_out,
  .freq_out, .dir_rev_out, .volt_pct_out, .manual_voltage_reduction_out);

/* bench/tb_top.sv */
// self-checking bench for the drive auxiliary block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dfs_pkg::*;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic run_fwd_in = 1'b0;
  logic run_rev_in = 1'b0;
  logic [1:0] dir_lock_in = 2'h0;
  dfs_ctrl_mode_t ctrl_mode_in = MODE_VF;
  logic high_freq_mode_in = 1'b0;
  logic [4:0] carrier_set_in = 5'h02;
  logic [4:0] var_carr_max_in = 5'h10;
  logic soft_pwm_en_in = 1'b0;
  logic auto_lower_en_in = 1'b0;
  logic overheat_in = 1'b0;
  logic [16:0] freq_ref_in = 17'h0_03e8;
  logic [16:0] freq_max_in = 17'h0_03e8;
  logic [15:0] acc_time_in = 16'h0064;
  logic [15:0] dec_time_in = 16'h0064;
  logic [3:0][7:0] s_time_in = '0;
  logic [2:0][13:0] jump_freq_in = '0;
  logic [7:0] jump_width_in = 8'h14;
  logic [3:0] ai2_func_in = 4'h0;
  logic [13:0] ai2_value_in = 14'h0064;
  logic [NUM_DI-1:0] di_level_in = '0;
  logic [NUM_DI-1:0][5:0] digital_input_function_select_in = '0;
  logic [6:0] mes_gain_in = 7'h3c;
  logic [16:0] mes_freq_in = 17'h0_01f4;
  logic speed_ok_in = 1'b1;
  logic [15:0] volt_recov_time_in = 16'h0000;
  logic [4:0] carrier_khz_out;
  logic [16:0] freq_out;
  logic dir_rev_out;
  logic running_out;
  logic [6:0] volt_pct_out;
  logic manual_voltage_reduction_out;
  int error_cnt = 0;
  int checks_done = 0;
  // 10 ms tick shortened to 40 cycles
  dfs_drive_aux #(.TICK_CYCLES_P(40)) u_dfs_drive_aux (.*);
  // 40 MHz clock
  initial begin
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_in);
    #2;
  endtask : step
  task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  task automatic ramp(input logic [16:0] target, input int lo, input int hi);
    step(lo);
    check("ramp early", 17'(freq_out === target), 17'h0_0000);
    step(hi);
    check("ramp done", freq_out, target);
  endtask : ramp
  task automatic settle(input string what, input logic [16:0] exp);
    step(20);
    check(what, freq_out, exp);
  endtask : settle
  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset();
    step(1);
    check("carrier", 17'(carrier_khz_out), 17'h0_0002);
    check("volt", 17'(volt_pct_out), 17'h0_0064);
    check("reduce", 17'(manual_voltage_reduction_out), 17'h0_0000);
  endtask : test_reset
  task automatic test_carrier();
    for (int i = 2; i <= 16; i++) begin
      carrier_set_in = 5'(i);
      step(4);
      check("carrier fixed", 17'(carrier_khz_out), 17'(i));
    end
    carrier_set_in = 5'h03;
    ctrl_mode_in = MODE_SENSORLESS_VECTOR;
    step(4);
    check("carrier vector", 17'(carrier_khz_out), 17'h0_0004);
    ctrl_mode_in = MODE_VF;
    carrier_set_in = 5'h0c;
    soft_pwm_en_in = 1'b1;
    step(4);
    check("carrier soft", 17'(carrier_khz_out), 17'h0_0008);
    soft_pwm_en_in = 1'b0;
    carrier_set_in = 5'h00;
    var_carr_max_in = 5'h06;
    step(4);
    check("carrier variable", 17'(carrier_khz_out), 17'h0_0006);
    carrier_set_in = 5'h01;
    var_carr_max_in = 5'h0a;
    step(4);
    check("carrier retained", 17'(carrier_khz_out), 17'h0_0006);
    carrier_set_in = 5'h0c;
    overheat_in = 1'b1;
    step(300);
    check("carrier kept", 17'(carrier_khz_out), 17'h0_000c);
    auto_lower_en_in = 1'b1;
    step(4100);
    check("carrier lowered", 17'(carrier_khz_out), 17'h0_000b);
    overheat_in = 1'b0;
    step(10);
    check("carrier restored", 17'(carrier_khz_out), 17'h0_000c);
    auto_lower_en_in = 1'b0;
  endtask : test_carrier
  task automatic test_ramp();
    run_fwd_in = 1'b1;
    ramp(17'h0_03e8, 3600, 800);
    check("running", 17'(running_out), 17'h0_0001);
    s_time_in = {8'h32, 8'h32, 8'h00, 8'h00};
    freq_ref_in = 17'h0_0000;
    ramp(17'h0_0000, 7000, 2000);
    s_time_in = {8'h00, 8'h00, 8'h32, 8'h32};
    freq_ref_in = 17'h0_03e8;
    ramp(17'h0_03e8, 7000, 2000);
  endtask : test_ramp
  task automatic test_jump();
    acc_time_in = 16'h0000;
    dec_time_in = 16'h0000;
    s_time_in = '0;
    freq_max_in = 17'h0_07d0;
    jump_freq_in[0] = 14'h0064;
    settle("band edge", 17'h0_0320);
    jump_freq_in[0] = 14'h0000;
    settle("band off", 17'h0_03e8);
    ai2_func_in = AI2_FUNC_JUMP;
    settle("fourth band", 17'h0_0320);
    ai2_func_in = 4'h0;
    jump_freq_in[0] = 14'h0064;
    jump_freq_in[1] = 14'h0082;
    freq_ref_in = 17'h0_0514;
    settle("merged bands", 17'h0_0320);
    freq_max_in = 17'h1_86a0;
    freq_ref_in = 17'h0_c350;
    jump_freq_in[1] = 14'h0000;
    jump_freq_in[0] = 14'h1388;
    settle("jump clamp", 17'h0_c350);
    high_freq_mode_in = 1'b1;
    settle("jump high range", 17'h0_c288);
    high_freq_mode_in = 1'b0;
    jump_freq_in = '0;
    freq_ref_in = 17'h0_03e8;
    run_fwd_in = 1'b0;
    run_rev_in = 1'b1;
    dir_lock_in = LOCK_FWD;
    settle("locked reverse", 17'h0_0000);
    check("locked dir", 17'(dir_rev_out), 17'h0_0000);
    dir_lock_in = LOCK_REV;
    settle("allowed reverse", 17'h0_03e8);
    check("reverse dir", 17'(dir_rev_out), 17'h0_0001);
  endtask : test_jump
  task automatic test_mes();
    digital_input_function_select_in[3] = DI_FUNC_MES;
    step(12);
    check("reduce idle", 17'(manual_voltage_reduction_out), 17'h0_0000);
    di_level_in[3] = 1'b1;
    step(12);
    check("reduce on", 17'(manual_voltage_reduction_out), 17'h0_0001);
    check("reduced volt", 17'(volt_pct_out), 17'h0_003c);
    mes_freq_in = 17'h0_05dc;
    step(12);
    check("reduce low ref", 17'(manual_voltage_reduction_out), 17'h0_0000);
    check("full volt", 17'(volt_pct_out), 17'h0_0064);
    mes_freq_in = 17'h0_01f4;
    speed_ok_in = 1'b0;
    step(12);
    check("reduce slow", 17'(manual_voltage_reduction_out), 17'h0_0000);
    speed_ok_in = 1'b1;
    di_level_in[3] = 1'b0;
    volt_recov_time_in = 16'h0064;
    step(12);
    di_level_in[3] = 1'b1;
    step(800);
    check("volt midway", 17'(volt_pct_out > 7'h3c && volt_pct_out < 7'h64), 17'h0_0001);
    step(1000);
    check("volt settled", 17'(volt_pct_out), 17'h0_003c);
  endtask : test_mes
  // main sequence: reset held 20 cycles, then scenarios
  initial begin
    step(20);
    resetn_in = 1'b1;
    test_reset();
    test_carrier();
    test_ramp();
    test_jump();
    test_mes();
    give_verdict();
  end
  // watchdog well beyond the expected 30000 cycles
  initial begin
    #2_000_000;
    error_cnt++;
    give_verdict();
  end
endmodule : tb_top
